// file: logic/adc_fn_cmd.sv
// Function-command engine: read memory, write memory and convert.
// Assumes the link layer delivers whole bytes and signals reset pulses.
`timescale 1ns/1ps
module adc_fn_cmd
  import adc_fn_pkg::*;
#(
  parameter int unsigned P_BIT_CYC = BIT_CYC_DEF,
  parameter int unsigned P_OFFSET_CYC = OFFSET_CYC_DEF
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_bus_reset,
  input wire logic i_fast_speed_set,
  input wire logic i_fn_start,
  input wire rx_byte_t i_rx,
  output logic o_rx_ready,
  output logic o_tx_valid,
  input wire logic i_tx_ready,
  output tx_byte_t o_tx,
  input wire logic [3:0][15:0] i_ain_sample,
  output logic o_fast_speed_flag,
  output logic o_busy
);
  typedef enum logic [4:0] {
    S_IDLE = 5'h00, S_CMD = 5'h01, S_ALO = 5'h02, S_AHI = 5'h03,
    S_RD_DATA = 5'h04, S_RD_CRCL = 5'h05, S_RD_CRCH = 5'h06,
    S_WR_DATA = 5'h07, S_WR_CRCL = 5'h08, S_WR_CRCH = 5'h09,
    S_WR_RB = 5'h0a, S_CV_MASK = 5'h0b, S_CV_PRE = 5'h0c,
    S_CV_CRCL = 5'h0d, S_CV_CRCH = 5'h0e, S_CV_DRAIN = 5'h0f,
    S_CV_GUARD = 5'h10, S_CV_OFS = 5'h11, S_CV_SEL = 5'h12,
    S_CV_RUN = 5'h13, S_CV_STAT = 5'h14, S_HALT = 5'h15
  } state_t;

  typedef struct packed {
    state_t st;
    logic fast;
    logic [7:0] cmd;
    logic [4:0] addr;
    logic [15:0] crc;
    logic [7:0] mask;
    logic [7:0] pre;
    logic [1:0] ch;
    logic [31:0] tmr;
    logic [31:0][7:0] mem;
  } core_t;

  core_t r_ff;
  core_t nxt_r;
  logic push_v;
  tx_byte_t push_d;
  logic buf_ready;
  logic buf_empty;
  logic rx_take;
  logic tx_take;
  logic crc_sent;

  // LSB-first CRC16 over one byte
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] x;
    x = c;
    for (int i = 0; i < 8; i++) begin
      if (x[0] ^ b[i]) begin
        x = (x >> 1) ^ CRC_POLY;
      end else begin
        x = x >> 1;
      end
    end
    return x;
  endfunction

  // Result bits for a resolution code
  function automatic logic [4:0] res_bits(input logic [3:0] code);
    return (code == 4'h0) ? 5'h10 : {1'b0, code};
  endfunction

  // Keeps the top bits that a conversion of this resolution produces
  function automatic logic [15:0] res_mask(input logic [3:0] code);
    return 16'hffff << (5'h10 - res_bits(code));
  endfunction

  // Writable bits per address; zero means the location ignores writes
  function automatic logic [7:0] wr_mask(input logic [4:0] a);
    logic [7:0] m;
    m = 8'h00;
    if (a >= ADDR_CTRL_FIRST && a < ADDR_ALARM_LO_A) begin
      m = a[0] ? WMASK_CTRL_HI : WMASK_CTRL_LO;
    end else if (a >= ADDR_ALARM_LO_A && a <= ADDR_ALARM_LAST) begin
      m = 8'hff;
    end else if (a == ADDR_CAL_CTRL) begin
      m = 8'hff;
    end
    return m;
  endfunction

  // Power-up contents of the register pages
  function automatic core_t reset_core();
    core_t c;
    c = '0;
    c.st = S_IDLE;
    for (int k = 0; k < 4; k++) begin
      c.mem[8 + 2 * k] = RST_CTRL_LO;
      c.mem[9 + 2 * k] = RST_CTRL_HI;
      c.mem[16 + 2 * k] = RST_ALARM_LO;
      c.mem[17 + 2 * k] = RST_ALARM_HI;
    end
    return c;
  endfunction

  // Bytes out go through the buffer so a slow link loses none
  byte_buffer #(
    .WIDTH($bits(tx_byte_t)),
    .DEPTH(2)
  ) u_tx_buf (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_flush(i_bus_reset),
    .i_valid(push_v),
    .o_ready(buf_ready),
    .i_data(push_d),
    .o_valid(o_tx_valid),
    .i_ready(i_tx_ready),
    .o_data(o_tx),
    .o_empty(buf_empty)
  );

  assign tx_take = push_v && buf_ready;
  assign crc_sent = o_tx_valid && i_tx_ready && o_tx.crc_msb;
  assign rx_take = i_rx.valid && o_rx_ready;
  assign o_fast_speed_flag = r_ff.fast;

  // Bytes are only taken in the states that expect one
  always_comb begin
    unique case (r_ff.st)
      S_CMD, S_ALO, S_AHI, S_WR_DATA, S_CV_MASK, S_CV_PRE: o_rx_ready = 1'b1;
      default: o_rx_ready = 1'b0;
    endcase
  end

  assign o_busy = (r_ff.st >= S_CV_DRAIN) && (r_ff.st <= S_CV_RUN);

  // Command sequencing, memory and conversion control
  always_comb begin
    logic [4:0] lo_i;
    logic [4:0] st_i;
    logic [3:0] code;
    logic [15:0] res;
    logic [7:0] m;
    logic [15:0] rm;
    lo_i = {2'h0, r_ff.ch, 1'b0};
    st_i = ADDR_CTRL_HI_A + {2'h0, r_ff.ch, 1'b0};
    code = r_ff.mem[lo_i + ADDR_CTRL_FIRST][3:0];
    // Mask held in a variable; a select straight on a call result is not portable
    rm = res_mask(code);
    res = i_ain_sample[r_ff.ch] & rm;
    m = rm[15:8];
    nxt_r = r_ff;
    push_v = 1'b0;
    push_d = '0;
    if (i_bus_reset) begin
      nxt_r.st = S_IDLE;
      nxt_r.fast = 1'b0;
    end else begin
      if (i_fast_speed_set) begin
        nxt_r.fast = 1'b1;
      end
      unique case (r_ff.st)
        S_IDLE: begin
          if (i_fn_start) begin
            nxt_r.st = S_CMD;
          end
        end
        S_CMD: begin
          if (rx_take) begin
            nxt_r.cmd = i_rx.data;
            nxt_r.crc = crc_byte(16'h0000, i_rx.data);
            if (i_rx.data == CMD_READ_MEM || i_rx.data == CMD_WRITE_MEM) begin
              nxt_r.st = S_ALO;
            end else if (i_rx.data == CMD_CONVERT) begin
              nxt_r.st = S_CV_MASK;
            end else begin
              nxt_r.st = S_HALT;
            end
          end
        end
        S_ALO: begin
          if (rx_take) begin
            nxt_r.addr = i_rx.data[4:0];
            nxt_r.crc = crc_byte(r_ff.crc, {3'h0, i_rx.data[4:0]});
            nxt_r.st = S_AHI;
          end
        end
        S_AHI: begin
          if (rx_take) begin
            nxt_r.crc = crc_byte(r_ff.crc, 8'h00);
            nxt_r.st = (r_ff.cmd == CMD_READ_MEM) ? S_RD_DATA : S_WR_DATA;
          end
        end
        S_RD_DATA: begin
          push_v = 1'b1;
          push_d.data = r_ff.mem[r_ff.addr];
          if (tx_take) begin
            nxt_r.crc = crc_byte(r_ff.crc, r_ff.mem[r_ff.addr]);
            if (r_ff.addr[2:0] == PAGE_LAST_OFS) begin
              nxt_r.st = S_RD_CRCL;
            end else begin
              nxt_r.addr = r_ff.addr + 5'h01;
            end
          end
        end
        S_RD_CRCL: begin
          push_v = 1'b1;
          push_d.data = r_ff.crc[7:0];
          if (tx_take) begin
            nxt_r.st = S_RD_CRCH;
          end
        end
        S_RD_CRCH: begin
          push_v = 1'b1;
          push_d.data = r_ff.crc[15:8];
          if (tx_take) begin
            if (r_ff.addr == ADDR_LAST) begin
              nxt_r.st = S_HALT;
            end else begin
              nxt_r.addr = r_ff.addr + 5'h01;
              nxt_r.crc = 16'h0000;
              nxt_r.st = S_RD_DATA;
            end
          end
        end
        S_WR_DATA: begin
          if (rx_take) begin
            nxt_r.pre = i_rx.data;
            nxt_r.crc = crc_byte(r_ff.crc, i_rx.data);
            nxt_r.st = S_WR_CRCL;
          end
        end
        S_WR_CRCL: begin
          push_v = 1'b1;
          push_d.data = r_ff.crc[7:0];
          if (tx_take) begin
            nxt_r.st = S_WR_CRCH;
          end
        end
        S_WR_CRCH: begin
          push_v = 1'b1;
          push_d.data = r_ff.crc[15:8];
          if (tx_take) begin
            // Store after the CRC; page 0 and calibration bytes other than ADDR_CAL_CTRL mask to nothing
            nxt_r.mem[r_ff.addr] = (r_ff.mem[r_ff.addr] & ~wr_mask(r_ff.addr))
                                 | (r_ff.pre & wr_mask(r_ff.addr));
            nxt_r.st = S_WR_RB;
          end
        end
        S_WR_RB: begin
          push_v = 1'b1;
          push_d.data = r_ff.mem[r_ff.addr];
          if (tx_take) begin
            if (r_ff.addr == ADDR_LAST) begin
              nxt_r.st = S_HALT;
            end else begin
              nxt_r.addr = r_ff.addr + 5'h01;
              nxt_r.crc = {11'h000, r_ff.addr + 5'h01};
              nxt_r.st = S_WR_DATA;
            end
          end
        end
        S_CV_MASK: begin
          if (rx_take) begin
            nxt_r.mask = i_rx.data;
            nxt_r.crc = crc_byte(r_ff.crc, i_rx.data);
            nxt_r.st = S_CV_PRE;
          end
        end
        S_CV_PRE: begin
          if (rx_take) begin
            nxt_r.pre = i_rx.data;
            nxt_r.crc = crc_byte(r_ff.crc, i_rx.data);
            nxt_r.st = S_CV_CRCL;
          end
        end
        S_CV_CRCL: begin
          push_v = 1'b1;
          push_d.data = r_ff.crc[7:0];
          if (tx_take) begin
            nxt_r.st = S_CV_CRCH;
          end
        end
        S_CV_CRCH: begin
          push_v = 1'b1;
          push_d.data = r_ff.crc[15:8];
          push_d.crc_msb = 1'b1;
          if (tx_take) begin
            nxt_r.st = S_CV_DRAIN;
          end
        end
        S_CV_DRAIN: begin
          // Guard time counts from the moment the link takes the CRC MSB
          if (crc_sent) begin
            nxt_r.tmr = '0;
            nxt_r.st = S_CV_GUARD;
          end
        end
        S_CV_GUARD: begin
          nxt_r.tmr = r_ff.tmr + 32'h1;
          if (r_ff.tmr == 32'(GUARD_CYC - 1)) begin
            for (int k = 0; k < 4; k++) begin
              if (r_ff.mask[k] && r_ff.pre[2*k +: 2] == 2'b01) begin
                nxt_r.mem[2*k] = 8'h00;
                nxt_r.mem[2*k + 1] = 8'h00;
              end else if (r_ff.mask[k] && r_ff.pre[2*k +: 2] == 2'b10) begin
                nxt_r.mem[2*k] = 8'hff;
                nxt_r.mem[2*k + 1] = 8'hff;
              end
            end
            nxt_r.tmr = '0;
            nxt_r.ch = 2'h0;
            // Analog kept active by the control byte skips the offset time
            if (r_ff.mem[ADDR_CAL_CTRL] == VCC_KEEP_ACTIVE) begin
              nxt_r.st = S_CV_SEL;
            end else begin
              nxt_r.st = S_CV_OFS;
            end
          end
        end
        S_CV_OFS: begin
          nxt_r.tmr = r_ff.tmr + 32'h1;
          if (r_ff.tmr == 32'(P_OFFSET_CYC - 1)) begin
            nxt_r.tmr = '0;
            nxt_r.st = S_CV_SEL;
          end
        end
        S_CV_SEL: begin
          nxt_r.tmr = '0;
          if (r_ff.mask[r_ff.ch]) begin
            nxt_r.st = S_CV_RUN;
          end else if (r_ff.ch == 2'h3) begin
            nxt_r.st = S_CV_STAT;
          end else begin
            nxt_r.ch = r_ff.ch + 2'h1;
          end
        end
        S_CV_RUN: begin
          nxt_r.tmr = r_ff.tmr + 32'h1;
          if (r_ff.tmr == 32'(res_bits(code)) * 32'(P_BIT_CYC) - 32'h1) begin
            nxt_r.mem[lo_i] = res[7:0];
            nxt_r.mem[lo_i + 5'h01] = res[15:8];
            nxt_r.mem[st_i][ALARM_HI_BIT] = res[15:8] > (r_ff.mem[st_i + 5'h08] & m);
            nxt_r.mem[st_i][ALARM_LO_BIT] = res[15:8] < (r_ff.mem[st_i + 5'h07] & m);
            nxt_r.st = (r_ff.ch == 2'h3) ? S_CV_STAT : S_CV_SEL;
            nxt_r.ch = r_ff.ch + 2'h1;
          end
        end
        S_CV_STAT: begin
          // One status byte at a time so few stale bytes queue up
          push_v = buf_empty;
          push_d.data = STATUS_DONE;
        end
        S_HALT: begin
        end
        default: nxt_r.st = S_HALT;
      endcase
      if (r_ff.st >= S_CV_GUARD && r_ff.st <= S_CV_RUN) begin
        push_v = buf_empty;
        push_d.data = STATUS_BUSY;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      r_ff <= reset_core();
    end else begin
      r_ff <= nxt_r;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence seq_crc_msb_out;
    r_ff.st == S_CV_DRAIN && crc_sent && !i_bus_reset;
  endsequence

  sequence seq_guard_hold;
    (r_ff.st == S_CV_GUARD && !push_v || r_ff.st == S_CV_GUARD)[*8];
  endsequence

  chk_fast_cleared: assert property (i_bus_reset |=> !o_fast_speed_flag)
    else $error("speed flag survived a reset pulse");
  chk_reset_ends: assert property (i_bus_reset |=> r_ff.st == S_IDLE && !o_tx_valid)
    else $error("command not ended by reset pulse");
  chk_high_addr_zero: assert property (r_ff.st == S_AHI && rx_take && !i_bus_reset
      |=> r_ff.crc == crc_byte($past(r_ff.crc), 8'h00))
    else $error("high address byte entered the CRC");
  chk_page_end_crc: assert property (r_ff.st == S_RD_DATA && tx_take && !i_bus_reset
      && r_ff.addr[2:0] == PAGE_LAST_OFS |=> r_ff.st == S_RD_CRCL ##1 push_v)
    else $error("page end did not lead to CRC");
  chk_next_page_clear: assert property (r_ff.st == S_RD_CRCH && tx_take && !i_bus_reset
      && r_ff.addr != ADDR_LAST |=> r_ff.crc == 16'h0000 && r_ff.st == S_RD_DATA)
    else $error("CRC not cleared for next page");
  chk_write_crc_load: assert property (r_ff.st == S_WR_RB && tx_take && !i_bus_reset
      && r_ff.addr != ADDR_LAST |=> r_ff.crc == {11'h000, r_ff.addr})
    else $error("incremented address not loaded into CRC");
  chk_page0_kept: assert property (r_ff.st == S_WR_CRCH && tx_take && !i_bus_reset
      && r_ff.addr < ADDR_CTRL_FIRST |=> $stable(r_ff.mem[r_ff.addr]))
    else $error("write changed a result byte");
  chk_guard_wait: assert property (seq_crc_msb_out |=> seq_guard_hold or
      (##[0:7] i_bus_reset))
    else $error("conversion began inside the guard time");
  chk_busy_zeros: assert property (push_v && o_busy |-> push_d.data == STATUS_BUSY)
    else $error("busy status not zero");
  chk_last_write_halt: assert property (r_ff.st == S_WR_RB && tx_take && !i_bus_reset
      && r_ff.addr == ADDR_LAST |=> r_ff.st == S_HALT ##1 !o_rx_ready)
    else $error("data accepted past the last address");
endmodule

// file: logic/adc_fn_pkg.sv
// Constants and carrier types for the function-command layer of the quad ADC.
// Assumes a bit-level link layer that turns slots into whole bytes.
package adc_fn_pkg;
  localparam logic [7:0] CMD_READ_MEM = 8'haa;
  localparam logic [7:0] CMD_WRITE_MEM = 8'h55;
  localparam logic [7:0] CMD_CONVERT = 8'h3c;
  localparam int ADDR_W = 5;
  localparam logic [4:0] ADDR_LAST = 5'h1f;
  localparam logic [4:0] ADDR_CAL_CTRL = 5'h1c;
  localparam logic [4:0] ADDR_CTRL_FIRST = 5'h08;
  localparam logic [4:0] ADDR_ALARM_LAST = 5'h17;
  localparam logic [4:0] ADDR_CTRL_HI_A = 5'h09;
  localparam logic [4:0] ADDR_ALARM_LO_A = 5'h10;
  localparam logic [2:0] PAGE_LAST_OFS = 3'h7;
  localparam logic [7:0] VCC_KEEP_ACTIVE = 8'h40;
  localparam logic [7:0] RST_CTRL_LO = 8'h08;
  localparam logic [7:0] RST_CTRL_HI = 8'h8c;
  localparam logic [7:0] RST_ALARM_LO = 8'h00;
  localparam logic [7:0] RST_ALARM_HI = 8'hff;
  localparam logic [7:0] WMASK_CTRL_LO = 8'hcf;
  localparam logic [7:0] WMASK_CTRL_HI = 8'hbd;
  localparam int ALARM_HI_BIT = 5;
  localparam int ALARM_LO_BIT = 4;
  localparam logic [7:0] STATUS_BUSY = 8'h00;
  localparam logic [7:0] STATUS_DONE = 8'hff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam int CLK_MHZ = 100;
  localparam int GUARD_US = 10;
  localparam int GUARD_CYC = GUARD_US * CLK_MHZ;
  localparam int BIT_US_MIN = 60;
  localparam int BIT_US_MAX = 80;
  localparam int BIT_CYC_DEF = BIT_US_MIN * CLK_MHZ;
  localparam int OFFSET_US_MAX = 160;
  localparam int OFFSET_CYC_DEF = OFFSET_US_MAX * CLK_MHZ;

  // Byte towards the link; crc_msb marks the last CRC byte of a convert
  typedef struct packed {
    logic crc_msb;
    logic [7:0] data;
  } tx_byte_t;

  // Byte from the link, valid held until the engine takes it with o_rx_ready
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rx_byte_t;
endpackage

// file: logic/byte_buffer.sv
// Small FIFO between the command engine and the link's transmit side.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module byte_buffer #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_flush,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data,
  output logic o_empty
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] slot;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } buf_t;

  buf_t r_ff;
  buf_t nxt_r;
  logic push;
  logic pop;

  // Handshakes straight from the fill count
  assign o_ready = (r_ff.cnt != (AW+1)'(DEPTH));
  assign o_valid = (r_ff.cnt != '0);
  assign o_empty = (r_ff.cnt == '0);
  assign o_data = r_ff.slot[r_ff.rp];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  // Pointers wrap at DEPTH, which need not be a power of two
  always_comb begin
    nxt_r = r_ff;
    if (push) begin
      nxt_r.slot[r_ff.wp] = i_data;
      nxt_r.wp = (r_ff.wp == AW'(DEPTH-1)) ? '0 : r_ff.wp + 1'b1;
    end
    if (pop) begin
      nxt_r.rp = (r_ff.rp == AW'(DEPTH-1)) ? '0 : r_ff.rp + 1'b1;
    end
    nxt_r.cnt = r_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (i_flush) begin
      nxt_r.wp = '0;
      nxt_r.rp = '0;
      nxt_r.cnt = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end
endmodule

// file: verif/adc_fn_cmd_bench.sv
// Self-checking bench for the function-command engine.
// Assumes short conversion counts so a full convert fits the run.
`timescale 1ns/1ps
module adc_fn_cmd_bench;
  import adc_fn_pkg::*;
  localparam int BIT_CYC = 4;
  localparam int OFS_CYC = 3;
  localparam int MIN_T = GUARD_CYC + OFS_CYC + 2 * 8 * BIT_CYC;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_bus_reset = 1'b0;
  logic i_fast_speed_set = 1'b0;
  logic i_fn_start = 1'b0;
  logic slow = 1'b0;
  logic [3:0][15:0] i_ain_sample = '0;
  rx_byte_t i_rx;
  tx_byte_t o_tx;
  logic o_rx_ready, o_tx_valid, i_tx_ready, o_fast_speed_flag, o_busy;
  logic [7:0] exp_q[$];
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;

  always #5 i_clk = ~i_clk;

  adc_fn_cmd #(.P_BIT_CYC(BIT_CYC), .P_OFFSET_CYC(OFS_CYC)) adc_fn_cmd_inst (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus_reset(i_bus_reset),
    .i_fast_speed_set(i_fast_speed_set), .i_fn_start(i_fn_start), .i_rx(i_rx),
    .o_rx_ready(o_rx_ready), .o_tx_valid(o_tx_valid), .i_tx_ready(i_tx_ready),
    .o_tx(o_tx), .i_ain_sample(i_ain_sample), .o_fast_speed_flag(o_fast_speed_flag),
    .o_busy(o_busy));

  link_master_model link_master_model_inst (
    .i_clk(i_clk), .i_slow(slow), .i_rx_ready(o_rx_ready), .i_tx_valid(o_tx_valid),
    .i_tx(o_tx), .o_rx(i_rx), .o_tx_ready(i_tx_ready));

  task automatic finish_test;
    if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard, well above the few thousand cycles needed
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Reflected CRC16, LSB first
  function automatic logic [15:0] crc_add(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    return c;
  endfunction

  task automatic expect_byte(input logic [7:0] exp, input string what);
    tx_byte_t b;
    int t;
    link_master_model_inst.get(b, t);
    check({8'h00, b.data}, {8'h00, exp}, what);
  endtask

  task automatic expect_crc(input logic [15:0] c);
    expect_byte(c[7:0], "crc low");
    expect_byte(c[15:8], "crc high");
  endtask

  // Abort; stale queued bytes are dropped with the engine's buffer
  task automatic bus_reset;
    @(posedge i_clk) i_bus_reset <= 1'b1;
    @(posedge i_clk) i_bus_reset <= 1'b0;
    repeat (4) @(posedge i_clk);
    link_master_model_inst.q.delete();
    link_master_model_inst.tq.delete();
  endtask

  task automatic start_cmd(input logic [7:0] cmd);
    @(posedge i_clk) i_fn_start <= 1'b1;
    @(posedge i_clk) i_fn_start <= 1'b0;
    link_master_model_inst.send(cmd);
  endtask

  task automatic start_addr(input logic [7:0] cmd, input logic [7:0] lo);
    start_cmd(cmd);
    link_master_model_inst.send(lo);
    link_master_model_inst.send(8'h12);
  endtask

  // Read from lo, checking exp_q bytes and a CRC at each page end
  task automatic read_check(input logic [7:0] lo);
    logic [4:0] a;
    logic [15:0] c;
    logic [7:0] b;
    a = lo[4:0];
    c = crc_add(crc_add(crc_add(16'h0, CMD_READ_MEM), {3'h0, a}), 8'h00);
    start_addr(CMD_READ_MEM, lo);
    while (exp_q.size() > 0) begin
      b = exp_q.pop_front();
      expect_byte(b, "read data");
      c = crc_add(c, b);
      if (a[2:0] == PAGE_LAST_OFS) begin
        expect_crc(c);
        c = 16'h0;
      end
      a = a + 5'h1;
    end
    bus_reset();
  endtask

  task automatic t_speed;
    check({15'h0, o_fast_speed_flag}, 16'h0, "speed after reset");
    @(posedge i_clk) i_fast_speed_set <= 1'b1;
    @(posedge i_clk) i_fast_speed_set <= 1'b0;
    @(posedge i_clk);
    check({15'h0, o_fast_speed_flag}, 16'h1, "speed set");
    bus_reset();
    check({15'h0, o_fast_speed_flag}, 16'h0, "speed cleared");
  endtask

  task automatic t_read;
    slow <= 1'b1;
    exp_q = {8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) exp_q.push_back(i[0] ? RST_CTRL_HI : RST_CTRL_LO);
    read_check(8'he5);
    slow <= 1'b0;
  endtask

  task automatic t_write;
    logic [15:0] c;
    c = crc_add(crc_add(crc_add(crc_add(16'h0, CMD_WRITE_MEM), 8'h10), 8'h00), 8'h5a);
    start_addr(CMD_WRITE_MEM, 8'h10);
    link_master_model_inst.send(8'h5a);
    expect_crc(c);
    expect_byte(8'h5a, "read-back");
    link_master_model_inst.send(8'h3c);
    expect_crc(crc_add(16'h0011, 8'h3c));
    expect_byte(8'h3c, "next read-back");
    bus_reset();
  endtask

  // Result, calibration byte 0x18 and last-address writes store nothing
  task automatic t_protect;
    logic [7:0] addrs[3] = '{8'h02, 8'h18, 8'h1f};
    logic [15:0] c;
    foreach (addrs[i]) begin
      c = crc_add(crc_add(crc_add(crc_add(16'h0, CMD_WRITE_MEM), addrs[i]), 8'h00), 8'hff);
      start_addr(CMD_WRITE_MEM, addrs[i]);
      link_master_model_inst.send(8'hff);
      expect_crc(c);
      expect_byte(8'h00, "protected read-back");
      repeat (3) @(posedge i_clk);
      if (i == 2) check({15'h0, o_rx_ready}, 16'h0, "halt at end");
      bus_reset();
    end
  endtask

  task automatic t_convert;
    tx_byte_t b;
    int t, t0, n;
    logic [15:0] c;
    c = crc_add(crc_add(crc_add(16'h0, CMD_CONVERT), 8'hf5), 8'hd0);
    i_ain_sample <= {16'h0, 16'habcd, 16'h0, 16'h1234};
    start_cmd(CMD_CONVERT);
    link_master_model_inst.send(8'hf5);
    link_master_model_inst.send(8'hd0);
    link_master_model_inst.get(b, t);
    check({7'h0, b}, {1'b0, c[7:0]}, "convert crc low");
    link_master_model_inst.get(b, t0);
    check({7'h0, b}, {1'b1, c[15:8]}, "convert crc high");
    check({15'h0, o_busy}, 16'h1, "busy");
    n = 0;
    do begin
      link_master_model_inst.get(b, t);
      if (b.data !== STATUS_DONE) check({8'h0, b.data}, {8'h0, STATUS_BUSY}, "status");
      n++;
    end while (b.data !== STATUS_DONE && n < 3000);
    check({15'h0, t - t0 >= MIN_T}, 16'h1, "early finish");
    check({15'h0, t - t0 <= MIN_T + 20}, 16'h1, "late finish");
    check({15'h0, o_busy}, 16'h0, "idle");
    bus_reset();
    exp_q = {8'h00, 8'h12, 8'h00, 8'h00, 8'h00, 8'hab, 8'h00, 8'h00};
    exp_q = {exp_q, 8'h08, 8'h9c, 8'h08, 8'h8c, 8'h08, 8'h8c, 8'h08, 8'h8c};
    read_check(8'h00);
    // Abort inside channel B's run: presets show, unselected and illegal pairs stay
    c = crc_add(crc_add(crc_add(16'h0, CMD_CONVERT), 8'h0a), 8'hc9);
    start_cmd(CMD_CONVERT);
    link_master_model_inst.send(8'h0a);
    link_master_model_inst.send(8'hc9);
    expect_crc(c);
    repeat (GUARD_CYC + OFS_CYC + 12) @(posedge i_clk);
    bus_reset();
    exp_q = {8'h00, 8'h12, 8'hff, 8'hff, 8'h00, 8'hab, 8'h00, 8'h00};
    exp_q = {exp_q, 8'h08, 8'h9c, 8'h08, 8'h8c, 8'h08, 8'h8c, 8'h08, 8'h8c};
    read_check(8'h00);
  endtask

  // Reset three cycles, then the scenarios in order
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_speed();
    t_read();
    t_write();
    t_protect();
    t_convert();
    finish_test();
  end
endmodule

// file: verif/link_master_model.sv
// Link-side master model: writes bytes to the engine, takes its bytes.
// Assumes the engine's byte handshakes and one shared clock.
`timescale 1ns/1ps
module link_master_model
  import adc_fn_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_slow,
  input wire logic i_rx_ready,
  input wire logic i_tx_valid,
  input wire tx_byte_t i_tx,
  output rx_byte_t o_rx,
  output logic o_tx_ready
);
  tx_byte_t q[$];
  int tq[$];
  int cyc = 0;

  // Idle values at time zero
  initial begin
    o_rx = '0;
    o_tx_ready = 1'b0;
  end

  // Take device bytes with a cycle stamp; slow mode stalls three of four
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (i_tx_valid && o_tx_ready) begin
      q.push_back(i_tx);
      tq.push_back(cyc);
    end
    o_tx_ready <= !i_slow || (cyc % 4 == 0);
  end

  // Hold the byte until taken; released data shows its inverse
  task automatic send(input logic [7:0] b);
    @(posedge i_clk);
    o_rx <= '{1'b1, b};
    do @(posedge i_clk); while (i_rx_ready !== 1'b1);
    o_rx <= '{1'b0, ~b};
  endtask

  // Next device byte and the cycle it was taken
  task automatic get(output tx_byte_t b, output int t);
    while (q.size() == 0) @(posedge i_clk);
    b = q.pop_front();
    t = tq.pop_front();
  endtask
endmodule
